//--- rtl/device_config_word_decode.v
// Configuration byte store with table access and decoded control outputs
`timescale 1ns/1ps
`include "config_decode_defines.vh"

module device_config_word_decode (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        por_n,
  // Table access port
  input  wire [23:0] tbl_addr,
  input  wire        tbl_rd,
  input  wire        tbl_wr,
  input  wire [7:0]  tbl_wdata,
  output reg  [7:0]  tbl_rdata_ff,
  output reg         tbl_rvalid_ff,
  output wire        tbl_busy,
  output reg         tbl_wr_done_ff,
  // Runtime inputs from the core
  input  wire        sw_brownout_on,
  input  wire        watchdog_sw_on,
  input  wire        sleep_mode,
  input  wire        stack_fault,
  // Shared reset / input pin
  input  wire        shared_pin_in,
  // Decoded controls
  output reg  [1:0]  brownout_level_sel_ff,
  output reg         brownout_reset_on_ff,
  output reg         powerup_timer_on_ff,
  output reg  [3:0]  watchdog_divide_sel_ff,
  output reg  [15:0] watchdog_divide_ratio_ff,
  output reg         watchdog_on_ff,
  output reg         ext_reset_pin_sel_ff,
  output reg         ext_reset_req_ff,
  output reg         shared_input_pin_ff,
  output reg         timer_osc_low_power_ff,
  output reg  [4:0]  analog_select_reset_ff,
  output reg         debug_on_ff,
  output reg         ext_instr_on_ff,
  output reg  [12:0] boot_block_words_ff,
  output reg         low_volt_prog_on_ff,
  output reg         stack_fault_reset_ff,
  output reg  [5:0]  code_guard_blk_ff,
  output reg         boot_code_guard_ff,
  output reg         eeprom_code_guard_ff,
  output reg  [5:0]  write_guard_blk_ff
);

  localparam [15:0] WR_CYCLES = `CFG_WRITE_CYCLES;

  // Write engine states
  localparam [0:0] ST_IDLE  = 1'b0;
  localparam [0:0] ST_WRITE = 1'b1;

  // Configuration cells, kept across device resets
  reg [7:0]  cell_bor_ff;
  reg [7:0]  cell_wdog_ff;
  reg [7:0]  cell_pin_ff;
  reg [7:0]  cell_core_ff;
  reg [7:0]  cell_cblk_ff;
  reg [7:0]  cell_cboot_ff;
  reg [7:0]  cell_wblk_ff;

  // Settings captured while reset is held
  reg [7:0]  held_bor_ff;
  reg [7:0]  held_wdog_ff;
  reg [7:0]  held_pin_ff;
  reg [7:0]  held_core_ff;
  reg [7:0]  held_cblk_ff;
  reg [7:0]  held_cboot_ff;
  reg [7:0]  held_wblk_ff;

  // Write engine
  reg        state_ff;
  reg [15:0] wr_cnt_ff;
  reg [23:0] wr_addr_ff;
  reg [7:0]  wr_data_ff;

  // Pin synchroniser
  reg        pin_meta_ff;
  reg        pin_sync_ff;

  // Write engine next values
  reg        nxt_state;
  reg [15:0] nxt_wr_cnt;
  reg        wr_commit;

  assign tbl_busy = (state_ff == ST_WRITE);

  // Mask of implemented bits for a byte address; zero means unmapped
  function [7:0] imp_mask;
    input [23:0] a;
    begin
      if (a == `CFG_ADDR_BOR_PUP) begin
        imp_mask = `CFG_IMP_BOR_PUP;
      end else if (a == `CFG_ADDR_WDOG) begin
        imp_mask = `CFG_IMP_WDOG;
      end else if (a == `CFG_ADDR_PIN_OSC) begin
        imp_mask = `CFG_IMP_PIN_OSC;
      end else if (a == `CFG_ADDR_CORE) begin
        imp_mask = `CFG_IMP_CORE;
      end else if (a == `CFG_ADDR_CODE_BLK) begin
        imp_mask = `CFG_IMP_CODE_BLK;
      end else if (a == `CFG_ADDR_CODE_BOOT) begin
        imp_mask = `CFG_IMP_CODE_BOOT;
      end else if (a == `CFG_ADDR_WRITE_BLK) begin
        imp_mask = `CFG_IMP_WRITE_BLK;
      end else begin
        imp_mask = 8'h00;
      end
    end
  endfunction

  // Guard bytes only ever lose ones
  function is_guard;
    input [23:0] a;
    begin
      is_guard = (a == `CFG_ADDR_CODE_BLK) || (a == `CFG_ADDR_CODE_BOOT) ||
                 (a == `CFG_ADDR_WRITE_BLK);
    end
  endfunction

  // New cell value: clear-only for guards, free otherwise, unimplemented zero
  function [7:0] merge;
    input [23:0] a;
    input [7:0]  old;
    input [7:0]  d;
    begin
      if (is_guard(a)) begin
        merge = old & d & imp_mask(a);
      end else begin
        merge = d & imp_mask(a);
      end
    end
  endfunction

  // Write engine: one byte, self-timed, further writes ignored while busy
  always @* begin
    nxt_state  = state_ff;
    nxt_wr_cnt = wr_cnt_ff;
    wr_commit  = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (tbl_wr && (imp_mask(tbl_addr) != 8'h00)) begin
          nxt_state  = ST_WRITE;
          nxt_wr_cnt = WR_CYCLES - 16'h0001;
        end
      end
      ST_WRITE: begin
        if (wr_cnt_ff == 16'h0000) begin
          nxt_state = ST_IDLE;
          wr_commit = 1'b1;
        end else begin
          nxt_wr_cnt = wr_cnt_ff - 16'h0001;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Write engine registers
  always @(posedge sys_clk) begin
    if (!por_n) begin
      state_ff       <= ST_IDLE;
      wr_cnt_ff      <= 16'h0000;
      wr_addr_ff     <= 24'h000000;
      wr_data_ff     <= 8'h00;
      tbl_wr_done_ff <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      wr_cnt_ff      <= nxt_wr_cnt;
      tbl_wr_done_ff <= wr_commit;
      // Latch address and data only when a write is accepted
      if ((state_ff == ST_IDLE) && (nxt_state == ST_WRITE)) begin
        wr_addr_ff <= tbl_addr;
        wr_data_ff <= tbl_wdata;
      end
    end
  end

  // Cells: unprogrammed at power-on, updated at the end of a write
  always @(posedge sys_clk) begin
    if (!por_n) begin
      cell_bor_ff   <= `CFG_DEF_BOR_PUP;
      cell_wdog_ff  <= `CFG_DEF_WDOG;
      cell_pin_ff   <= `CFG_DEF_PIN_OSC;
      cell_core_ff  <= `CFG_DEF_CORE;
      cell_cblk_ff  <= `CFG_DEF_CODE_BLK;
      cell_cboot_ff <= `CFG_DEF_CODE_BOOT;
      cell_wblk_ff  <= `CFG_DEF_WRITE_BLK;
    end else if (wr_commit) begin
      if (wr_addr_ff == `CFG_ADDR_BOR_PUP) begin
        cell_bor_ff <= merge(wr_addr_ff, cell_bor_ff, wr_data_ff);
      end else if (wr_addr_ff == `CFG_ADDR_WDOG) begin
        cell_wdog_ff <= merge(wr_addr_ff, cell_wdog_ff, wr_data_ff);
      end else if (wr_addr_ff == `CFG_ADDR_PIN_OSC) begin
        cell_pin_ff <= merge(wr_addr_ff, cell_pin_ff, wr_data_ff);
      end else if (wr_addr_ff == `CFG_ADDR_CORE) begin
        cell_core_ff <= merge(wr_addr_ff, cell_core_ff, wr_data_ff);
      end else if (wr_addr_ff == `CFG_ADDR_CODE_BLK) begin
        cell_cblk_ff <= merge(wr_addr_ff, cell_cblk_ff, wr_data_ff);
      end else if (wr_addr_ff == `CFG_ADDR_CODE_BOOT) begin
        cell_cboot_ff <= merge(wr_addr_ff, cell_cboot_ff, wr_data_ff);
      end else if (wr_addr_ff == `CFG_ADDR_WRITE_BLK) begin
        cell_wblk_ff <= merge(wr_addr_ff, cell_wblk_ff, wr_data_ff);
      end
    end
  end

  // Table read: one cycle latency, unmapped reads return zero
  always @(posedge sys_clk) begin
    if (!por_n) begin
      tbl_rdata_ff  <= 8'h00;
      tbl_rvalid_ff <= 1'b0;
    end else begin
      tbl_rvalid_ff <= tbl_rd;
      if (tbl_rd) begin
        if (tbl_addr == `CFG_ADDR_BOR_PUP) begin
          tbl_rdata_ff <= cell_bor_ff;
        end else if (tbl_addr == `CFG_ADDR_WDOG) begin
          tbl_rdata_ff <= cell_wdog_ff;
        end else if (tbl_addr == `CFG_ADDR_PIN_OSC) begin
          tbl_rdata_ff <= cell_pin_ff;
        end else if (tbl_addr == `CFG_ADDR_CORE) begin
          tbl_rdata_ff <= cell_core_ff;
        end else if (tbl_addr == `CFG_ADDR_CODE_BLK) begin
          tbl_rdata_ff <= cell_cblk_ff;
        end else if (tbl_addr == `CFG_ADDR_CODE_BOOT) begin
          tbl_rdata_ff <= cell_cboot_ff;
        end else if (tbl_addr == `CFG_ADDR_WRITE_BLK) begin
          tbl_rdata_ff <= cell_wblk_ff;
        end else begin
          tbl_rdata_ff <= 8'h00;
        end
      end
    end
  end

  // Capture while reset is held; a reprogrammed byte waits for the next reset
  always @(posedge sys_clk) begin
    if (!rst_n || !por_n) begin
      held_bor_ff   <= cell_bor_ff;
      held_wdog_ff  <= cell_wdog_ff;
      held_pin_ff   <= cell_pin_ff;
      held_core_ff  <= cell_core_ff;
      held_cblk_ff  <= cell_cblk_ff;
      held_cboot_ff <= cell_cboot_ff;
      held_wblk_ff  <= cell_wblk_ff;
    end
  end

  // Two-stage synchroniser for the shared pin
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end else begin
      pin_meta_ff <= shared_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Decoded outputs, registered from held settings and runtime inputs
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      brownout_level_sel_ff    <= 2'h0;
      brownout_reset_on_ff     <= 1'b0;
      powerup_timer_on_ff      <= 1'b0;
      watchdog_divide_sel_ff   <= 4'h0;
      watchdog_divide_ratio_ff <= 16'h0001;
      watchdog_on_ff           <= 1'b0;
      ext_reset_pin_sel_ff     <= 1'b0;
      ext_reset_req_ff         <= 1'b0;
      shared_input_pin_ff      <= 1'b0;
      timer_osc_low_power_ff   <= 1'b0;
      analog_select_reset_ff   <= 5'h00;
      debug_on_ff              <= 1'b0;
      ext_instr_on_ff          <= 1'b0;
      boot_block_words_ff      <= 13'h0000;
      low_volt_prog_on_ff      <= 1'b0;
      stack_fault_reset_ff     <= 1'b0;
      code_guard_blk_ff        <= 6'h00;
      boot_code_guard_ff       <= 1'b0;
      eeprom_code_guard_ff     <= 1'b0;
      write_guard_blk_ff       <= 6'h00;
    end else begin
      // Level code passes straight through: 11 lowest, 00 highest trip
      brownout_level_sel_ff <= held_bor_ff[`POS_BOR_LVL_HI:`POS_BOR_LVL_LO];
      case (held_bor_ff[`POS_BOR_MODE_HI:`POS_BOR_MODE_LO])
        `BOR_MODE_HW:       brownout_reset_on_ff <= 1'b1;
        `BOR_MODE_HW_AWAKE: brownout_reset_on_ff <= ~sleep_mode;
        `BOR_MODE_SW:       brownout_reset_on_ff <= sw_brownout_on;
        default:            brownout_reset_on_ff <= 1'b0;
      endcase
      // Own bit only, no brown-out term
      powerup_timer_on_ff <= ~held_bor_ff[`POS_PUP_N];
      watchdog_divide_sel_ff <= held_wdog_ff[`POS_WDOG_DIV_HI:`POS_WDOG_DIV_LO];
      watchdog_divide_ratio_ff <=
        16'h0001 << held_wdog_ff[`POS_WDOG_DIV_HI:`POS_WDOG_DIV_LO];
      watchdog_on_ff <= held_wdog_ff[`POS_WDOG_HW] | watchdog_sw_on;
      // Pin goes either to the reset logic or to the port, never both
      ext_reset_pin_sel_ff <= held_pin_ff[`POS_EXT_RST_SEL];
      ext_reset_req_ff     <= held_pin_ff[`POS_EXT_RST_SEL] & ~pin_sync_ff;
      shared_input_pin_ff  <= ~held_pin_ff[`POS_EXT_RST_SEL] & pin_sync_ff;
      timer_osc_low_power_ff <= held_pin_ff[`POS_TMR_OSC_LP];
      analog_select_reset_ff <= {5{held_pin_ff[`POS_PORT_ANALOG]}};
      debug_on_ff     <= ~held_core_ff[`POS_DEBUG_N];
      ext_instr_on_ff <= held_core_ff[`POS_EXT_INSTR];
      if (held_core_ff[`POS_BOOT_SIZE_HI]) begin
        boot_block_words_ff <= `BOOT_WORDS_4K;
      end else if (held_core_ff[`POS_BOOT_SIZE_LO]) begin
        boot_block_words_ff <= `BOOT_WORDS_2K;
      end else begin
        boot_block_words_ff <= `BOOT_WORDS_1K;
      end
      low_volt_prog_on_ff  <= held_core_ff[`POS_LOW_VOLT];
      stack_fault_reset_ff <= held_core_ff[`POS_STACK_RST] & stack_fault;
      // Guards are active high here: a cleared cell bit means protected
      code_guard_blk_ff    <= ~held_cblk_ff[5:0];
      boot_code_guard_ff   <= ~held_cboot_ff[`POS_BOOT_GUARD];
      eeprom_code_guard_ff <= ~held_cboot_ff[`POS_EEPROM_GUARD];
      write_guard_blk_ff   <= ~held_wblk_ff[5:0];
    end
  end

endmodule

//--- rtl/config_decode_defines.vh
// Offsets, field positions, defaults and timing for the configuration byte decoder
// Behaviour
// - Level field 11 lowest trip, 00 highest
// - Mode 11: brown-out on, software bit ignored
// - Mode 10: on while awake, off asleep
// - Mode 01: software bit alone decides brown-out
// - Mode 00: brown-out always off
// - Power-up timer bit low means timer on
// - Power-up timer decoded apart from brown-out
// - Watchdog divide ratio is two to field
// - Watchdog bit set forces on, else software
// - Reset-pin bit picks external reset or input
// - Timer oscillator bit selects low-power operation
// - Analog bit sets port pins reset analog state
// - Debugger bit low dedicates two debug pins
// - Extended instruction bit enables indexed addressing
// - Boot size codes 1x 4K, 01 2K, 00 1K
// - Low-voltage bit permits single-supply programming entry
// - Stack fault bit makes stack faults reset
// - Code guard bit low protects its block
// - Boot and EEPROM code guards, active low
// - Write guard bit low blocks block writes
// - Guard bits clear-only; unimplemented bits read zero
`ifndef CONFIG_DECODE_DEFINES_VH
`define CONFIG_DECODE_DEFINES_VH

// Byte addresses in configuration space
`define CFG_SPACE_BASE      24'h300000
`define CFG_ADDR_BOR_PUP    24'h300002
`define CFG_ADDR_WDOG       24'h300003
`define CFG_ADDR_PIN_OSC    24'h300005
`define CFG_ADDR_CORE       24'h300006
`define CFG_ADDR_CODE_BLK   24'h300008
`define CFG_ADDR_CODE_BOOT  24'h300009
`define CFG_ADDR_WRITE_BLK  24'h30000A

// Unprogrammed values
`define CFG_DEF_BOR_PUP     8'h1F
`define CFG_DEF_WDOG        8'h1F
`define CFG_DEF_PIN_OSC     8'h82
`define CFG_DEF_CORE        8'h85
`define CFG_DEF_CODE_BLK    8'h3F
`define CFG_DEF_CODE_BOOT   8'hC0
`define CFG_DEF_WRITE_BLK   8'h3F

// Implemented bits; all others read as zero
`define CFG_IMP_BOR_PUP     8'h1F
`define CFG_IMP_WDOG        8'h1F
`define CFG_IMP_PIN_OSC     8'h86
`define CFG_IMP_CORE        8'hF5
`define CFG_IMP_CODE_BLK    8'h3F
`define CFG_IMP_CODE_BOOT   8'hC0
`define CFG_IMP_WRITE_BLK   8'h3F

// Field positions
`define POS_PUP_N           0
`define POS_BOR_MODE_LO     1
`define POS_BOR_MODE_HI     2
`define POS_BOR_LVL_LO      3
`define POS_BOR_LVL_HI      4
`define POS_WDOG_HW         0
`define POS_WDOG_DIV_LO     1
`define POS_WDOG_DIV_HI     4
`define POS_EXT_RST_SEL     7
`define POS_TMR_OSC_LP      2
`define POS_PORT_ANALOG     1
`define POS_DEBUG_N         7
`define POS_EXT_INSTR       6
`define POS_BOOT_SIZE_HI    5
`define POS_BOOT_SIZE_LO    4
`define POS_LOW_VOLT        2
`define POS_STACK_RST       0
`define POS_EEPROM_GUARD    7
`define POS_BOOT_GUARD      6

// Brown-out mode codes
`define BOR_MODE_HW         2'h3
`define BOR_MODE_HW_AWAKE   2'h2
`define BOR_MODE_SW         2'h1
`define BOR_MODE_OFF        2'h0

// Boot block sizes in words
`define BOOT_WORDS_4K       13'h1000
`define BOOT_WORDS_2K       13'h0800
`define BOOT_WORDS_1K       13'h0400

// Self-timed byte write: time in ns and derived cycle count at 10 ns
`define CFG_WRITE_TIME_NS   2000
`define CLK_PERIOD_NS       10
`define CFG_WRITE_CYCLES    ((`CFG_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- bench/cfg_decode_checker_assertions.sv
// Concurrent checks on the configuration decoder's table port and outputs
`timescale 1ns/1ps
module cfg_decode_checker (
  // Clock and resets
  input wire        sys_clk,
  input wire        rst_n,
  input wire        por_n,
  // Table port
  input wire [23:0] tbl_addr,
  input wire        tbl_rd,
  input wire        tbl_wr,
  input wire [7:0]  tbl_rdata_ff,
  input wire        tbl_rvalid_ff,
  input wire        tbl_busy,
  input wire        tbl_wr_done_ff,
  // Runtime inputs and decoded outputs
  input wire        watchdog_sw_on,
  input wire        stack_fault,
  input wire        watchdog_on_ff,
  input wire        stack_fault_reset_ff,
  input wire [5:0]  code_guard_blk_ff,
  input wire [12:0] boot_block_words_ff
);
  // Checks pause in either reset; decoded outputs are forced in device reset, table port outputs in power-on reset
  wire live = rst_n & por_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!live);

  property p_rvalid_after_rd; tbl_rd |=> tbl_rvalid_ff; endproperty
  a_rvalid_after_rd: assert property (p_rvalid_after_rd) else $error("read not answered");
  property p_rvalid_only_rd; tbl_rvalid_ff |-> $past(tbl_rd); endproperty
  a_rvalid_only_rd: assert property (p_rvalid_only_rd) else $error("stray read valid");
  property p_unmapped_zero; tbl_rd && tbl_addr == 24'h300004 |=> tbl_rdata_ff == 8'h00; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped byte not zero");
  property p_busy_after_wr;
    tbl_wr && !tbl_busy && tbl_addr inside {24'h300002, 24'h300008} |=> tbl_busy; endproperty
  a_busy_after_wr: assert property (p_busy_after_wr) else $error("write did not start");
  property p_done_after_busy; $fell(tbl_busy) |-> tbl_wr_done_ff; endproperty
  a_done_after_busy: assert property (p_done_after_busy) else $error("no write done");
  property p_wdog_sw; $past(live) && $past(watchdog_sw_on) |-> watchdog_on_ff; endproperty
  a_wdog_sw: assert property (p_wdog_sw) else $error("software watchdog ignored");
  property p_stack_only_fault; stack_fault_reset_ff |-> $past(stack_fault); endproperty
  a_stack_only_fault: assert property (p_stack_only_fault) else $error("stack reset no fault");
  property p_held_stable; $past(live) && $past(live, 2) |->
    $stable(code_guard_blk_ff) && $stable(boot_block_words_ff); endproperty
  a_held_stable: assert property (p_held_stable) else $error("setting moved while running");
endmodule

bind device_config_word_decode cfg_decode_checker i_checker (
  .sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .tbl_addr(tbl_addr),
  .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_rdata_ff(tbl_rdata_ff),
  .tbl_rvalid_ff(tbl_rvalid_ff), .tbl_busy(tbl_busy), .tbl_wr_done_ff(tbl_wr_done_ff),
  .watchdog_sw_on(watchdog_sw_on), .stack_fault(stack_fault),
  .watchdog_on_ff(watchdog_on_ff), .stack_fault_reset_ff(stack_fault_reset_ff),
  .code_guard_blk_ff(code_guard_blk_ff), .boot_block_words_ff(boot_block_words_ff)
);

//--- bench/testbench.sv
// Self-checking bench for the configuration byte decoder
`timescale 1ns/1ps
module testbench;
  // Driven inputs
  logic        sys_clk, rst_n, por_n, tbl_rd, tbl_wr, shared_pin_in;
  logic [23:0] tbl_addr;
  logic [7:0]  tbl_wdata, rd_byte;
  logic        sw_brownout_on, watchdog_sw_on, sleep_mode, stack_fault;
  // Observed outputs
  logic [7:0]  tbl_rdata_ff;
  logic        tbl_rvalid_ff, tbl_busy, tbl_wr_done_ff, brownout_reset_on_ff;
  logic        powerup_timer_on_ff, watchdog_on_ff, ext_reset_pin_sel_ff, ext_reset_req_ff;
  logic        shared_input_pin_ff, timer_osc_low_power_ff, debug_on_ff, ext_instr_on_ff;
  logic        low_volt_prog_on_ff, stack_fault_reset_ff, boot_code_guard_ff;
  logic        eeprom_code_guard_ff;
  logic [1:0]  brownout_level_sel_ff;
  logic [3:0]  watchdog_divide_sel_ff;
  logic [15:0] watchdog_divide_ratio_ff;
  logic [4:0]  analog_select_reset_ff;
  logic [12:0] boot_block_words_ff;
  logic [5:0]  code_guard_blk_ff, write_guard_blk_ff;
  int          mismatches = 0;
  int          check_count = 0;

  device_config_word_decode i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .tbl_addr(tbl_addr),
    .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_wdata(tbl_wdata), .tbl_rdata_ff(tbl_rdata_ff),
    .tbl_rvalid_ff(tbl_rvalid_ff), .tbl_busy(tbl_busy), .tbl_wr_done_ff(tbl_wr_done_ff),
    .sw_brownout_on(sw_brownout_on), .watchdog_sw_on(watchdog_sw_on),
    .sleep_mode(sleep_mode), .stack_fault(stack_fault), .shared_pin_in(shared_pin_in),
    .brownout_level_sel_ff(brownout_level_sel_ff),
    .brownout_reset_on_ff(brownout_reset_on_ff), .powerup_timer_on_ff(powerup_timer_on_ff),
    .watchdog_divide_sel_ff(watchdog_divide_sel_ff),
    .watchdog_divide_ratio_ff(watchdog_divide_ratio_ff), .watchdog_on_ff(watchdog_on_ff),
    .ext_reset_pin_sel_ff(ext_reset_pin_sel_ff), .ext_reset_req_ff(ext_reset_req_ff),
    .shared_input_pin_ff(shared_input_pin_ff), .timer_osc_low_power_ff(timer_osc_low_power_ff),
    .analog_select_reset_ff(analog_select_reset_ff), .debug_on_ff(debug_on_ff),
    .ext_instr_on_ff(ext_instr_on_ff), .boot_block_words_ff(boot_block_words_ff),
    .low_volt_prog_on_ff(low_volt_prog_on_ff), .stack_fault_reset_ff(stack_fault_reset_ff),
    .code_guard_blk_ff(code_guard_blk_ff), .boot_code_guard_ff(boot_code_guard_ff),
    .eeprom_code_guard_ff(eeprom_code_guard_ff), .write_guard_blk_ff(write_guard_blk_ff)
  );

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Compare seen against expected, four-state exact
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One-cycle read; answer is due exactly one edge later
  task automatic rd(input logic [23:0] a);
    @(negedge sys_clk);
    tbl_rd = 1'b1;
    tbl_addr = a;
    @(negedge sys_clk);
    tbl_rd = 1'b0;
    chk(tbl_rvalid_ff, 1'b1);
    rd_byte = tbl_rdata_ff;
  endtask

  // Self-timed byte write, bounded wait for the done pulse
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    tbl_wr = 1'b1;
    tbl_addr = a;
    tbl_wdata = d;
    @(negedge sys_clk);
    tbl_wr = 1'b0;
    chk(tbl_busy, 1'b1);
    n = 0;
    while (tbl_wr_done_ff !== 1'b1) begin
      n++;
      if (n > 300) begin
        mismatches++;
        tally_and_finish;
      end
      @(negedge sys_clk);
    end
  endtask

  // Device reset alone; cells survive, settings reload
  task automatic reboot;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(4);
  endtask

  task automatic test_defaults;
    logic [7:0] dflt [9] = '{8'h1F, 8'h1F, 8'h00, 8'h82, 8'h85, 8'h00, 8'h3F, 8'hC0, 8'h3F};
    for (int i = 0; i < 9; i++) begin
      rd(24'h300002 + i);
      chk(rd_byte, dflt[i]);
    end
    chk(ext_reset_pin_sel_ff, 1'b1);
    chk(ext_reset_req_ff, 1'b1);
    chk(shared_input_pin_ff, 1'b0);
    chk(analog_select_reset_ff, 5'h1F);
    chk(timer_osc_low_power_ff, 1'b0);
    chk(debug_on_ff, 1'b0);
    chk(ext_instr_on_ff, 1'b0);
    chk(low_volt_prog_on_ff, 1'b1);
    chk(watchdog_divide_ratio_ff, 16'h8000);
    chk({boot_code_guard_ff, eeprom_code_guard_ff, code_guard_blk_ff}, 8'h00);
  endtask

  task automatic test_brownout;
    logic [1:0] m;
    logic [1:0] l;
    logic       e;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      l = ~m;
      wr(24'h300002, {3'h7, l, m, m[0]});
      rd(24'h300002);
      chk(rd_byte, {3'h0, l, m, m[0]});
      reboot;
      chk(brownout_level_sel_ff, l);
      chk(powerup_timer_on_ff, !m[0]);
      for (int s = 0; s < 4; s++) begin
        sw_brownout_on = s[0];
        sleep_mode = s[1];
        tick(2);
        e = (m == 2'h3) ? 1'b1 : (m == 2'h2) ? !s[1] : (m == 2'h1) ? s[0] : 1'b0;
        chk(brownout_reset_on_ff, e);
      end
    end
  endtask

  task automatic test_watchdog;
    logic [3:0] sel;
    for (int i = 0; i < 4; i++) begin
      sel = 4'(i * 5);
      wr(24'h300003, {3'h0, sel, i[0]});
      reboot;
      chk(watchdog_divide_ratio_ff, 16'h1 << sel);
      chk(watchdog_divide_sel_ff, sel);
      for (int s = 0; s < 2; s++) begin
        watchdog_sw_on = s[0];
        tick(2);
        chk(watchdog_on_ff, i[0] | s[0]);
      end
    end
  endtask

  // Pin cell picks plain input; core cell sweeps every boot size code
  task automatic test_core;
    logic [1:0] b;
    wr(24'h300005, 8'h7D);
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      wr(24'h300006, {2'h1, b, 1'b1, b[0], 1'b1, b[1]});
      reboot;
      chk({ext_reset_pin_sel_ff, timer_osc_low_power_ff}, 2'h1);
      chk(analog_select_reset_ff, 5'h00);
      chk({debug_on_ff, ext_instr_on_ff, low_volt_prog_on_ff}, {2'h3, b[0]});
      chk(boot_block_words_ff, b[1] ? 13'h1000 : b[0] ? 13'h0800 : 13'h0400);
      shared_pin_in = b[0];
      stack_fault = 1'b1;
      tick(4);
      chk({shared_input_pin_ff, ext_reset_req_ff}, {b[0], 1'b0});
      chk(stack_fault_reset_ff, b[1]);
      stack_fault = 1'b0;
    end
  endtask

  // Guard cells only ever clear; settings wait for a device reset
  task automatic test_guards;
    wr(24'h300008, 8'hD5);
    wr(24'h300008, 8'h3F);
    rd(24'h300008);
    chk(rd_byte, 8'h15);
    wr(24'h300009, 8'h7F);
    wr(24'h30000A, 8'h2A);
    rd(24'h300009);
    chk(rd_byte, 8'h40);
    chk(code_guard_blk_ff, 6'h00);
    reboot;
    chk(code_guard_blk_ff, 6'h2A);
    chk({boot_code_guard_ff, eeprom_code_guard_ff}, 2'h1);
    chk(write_guard_blk_ff, 6'h15);
  endtask

  // Power-on and device reset together, then the scenarios
  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    tbl_rd = 1'b0;
    tbl_wr = 1'b0;
    tbl_addr = 24'h000000;
    tbl_wdata = 8'h00;
    sw_brownout_on = 1'b0;
    watchdog_sw_on = 1'b0;
    sleep_mode = 1'b0;
    stack_fault = 1'b0;
    shared_pin_in = 1'b0;
    tick(6);
    por_n = 1'b1;
    tick(2);
    rst_n = 1'b1;
    tick(4);
    test_defaults;
    test_brownout;
    test_watchdog;
    test_core;
    test_guards;
    tally_and_finish;
  end
endmodule
